// *** verilog/dbg_regs.sv ***
// Purpose: Debug register block: snapshots, cause, breakpoints, watchpoints, scratch.
// Assumes: Core clock only; all inputs come from logic on that clock.
// Notes: Read data appears one cycle after the access.
//
// Notes on behaviour
// - Capture saved status word on debugger entry.
// - Capture saved program counter, debugger read/write.
// - Capture saved stack pointer on entry.
// - Remote read thread operand, eight bits.
// - Remote read register operand, five bits.
// - Three-bit cause code, reset zero.
// - Unit index, zero for host or call.
// - Lowest index wins among simultaneous hits.
// - Causing thread number, zero for host.
// - Data watch hit loads effective address.
// - Resource watch hit loads resource identifier.
// - Stop mask halts threads outside debug.
// - Eight scratch words shared with configuration.
// - Four instruction breakpoints with address registers.
// - Per-thread enable mask per breakpoint.
// - Condition bit selects equal or differ.
// - Breakpoint inactive unless enable set.
// - Four data watch first addresses.
// - Four data watch second addresses.
// - Control bit enables triggering on loads.
`timescale 1ns/10ps
`include "dbg_consts.svh"
module dbg_regs #(
    parameter int NUM_THREADS = 8,
    parameter int NUM_UNITS = 4,
    parameter int NUM_SCRATCH = 8
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Processor-status register port
    input wire dbg_pkg::reg_req_t i_reg,
    output logic [31:0] o_reg_rdata,
    // Tile configuration port to the scratch words
    input wire dbg_pkg::reg_req_t i_cfg,
    input wire logic i_cfg_wr_lock,
    output logic [31:0] o_cfg_rdata,
    // Core state
    input wire logic i_debug_mode,
    input wire dbg_pkg::saved_state_t i_saved,
    input wire logic i_pc_valid,
    input wire logic [31:0] i_pc,
    input wire logic [7:0] i_pc_thread,
    input wire dbg_pkg::mem_access_t i_mem,
    // Debug requests from outside
    input wire logic i_host_req,
    input wire logic i_swcall_req,
    input wire logic [7:0] i_swcall_thread,
    input wire logic [3:0] i_res_hit,
    input wire logic [7:0] i_res_thread,
    input wire logic [31:0] i_res_id,
    // To the core
    output logic o_debug_irq,
    output logic [7:0] o_thread_stop,
    output logic [7:0] o_remote_thread,
    output logic [4:0] o_remote_reg
);
    if (NUM_THREADS < 1 || NUM_THREADS > 8 || NUM_UNITS != 4 || NUM_SCRATCH != 8) begin : g_bad
        $error("Unsupported parameter values.");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Storage.
    logic [31:0] status_r;
    logic [31:0] spc_r;
    logic [31:0] ssp_r;
    logic [7:0] remote_thread_r;
    logic [4:0] remote_reg_r;
    logic [2:0] cause_r;
    logic [1:0] cause_index_r;
    logic [7:0] cause_thread_r;
    logic [31:0] info_r;
    logic [7:0] stop_mask_r;
    logic [31:0] scratch_r [NUM_SCRATCH];
    logic [31:0] ibrk_addr_r [NUM_UNITS];
    logic [31:0] ibrk_ctrl_r [NUM_UNITS];
    logic [31:0] dw_first_r [NUM_UNITS];
    logic [31:0] dw_second_r [NUM_UNITS];
    logic [31:0] dw_ctrl_r [NUM_UNITS];

    // Lowest set bit of a hit vector; used for breakpoint, data watch and resource hits.
    function automatic logic [1:0] lowest_index(input logic [3:0] hits);
        logic [1:0] idx;
        idx = 2'h0;
        for (int k = 3; k >= 0; k--) begin
            if (hits[k]) begin
                idx = 2'(k);
            end
        end
        return idx;
    endfunction : lowest_index

    // Register numbers inside a block of four consecutive entries.
    function automatic logic in_block4(input logic [7:0] addr, input logic [7:0] base);
        return addr[7:2] == base[7:2];
    endfunction : in_block4

    ////////////////////////////////////////////////////////////////////////////////
    // Breakpoint and watchpoint matching.
    logic [3:0] ibrk_hit;
    logic [3:0] dw_hit;
    genvar g;
    generate
        for (g = 0; g < NUM_UNITS; g++) begin : g_unit
            logic above;
            logic below;
            logic thread_ok;
            ibrk_match #(
                .NUM_THREADS(NUM_THREADS)
            ) u_ibrk (
                .i_addr(ibrk_addr_r[g]),
                .i_ctrl(ibrk_ctrl_r[g]),
                .i_valid(i_pc_valid),
                .i_pc(i_pc),
                .i_thread(i_pc_thread),
                .o_hit(ibrk_hit[g])
            );
            always_comb begin
                above = i_mem.addr >= dw_first_r[g];
                below = i_mem.addr <= dw_second_r[g];
                thread_ok = 1'b0;
                if (i_mem.thread < 8'(NUM_THREADS)) begin
                    thread_ok = dw_ctrl_r[g][`DBG_CTRL_THREAD_LSB + int'(i_mem.thread)];
                end
                dw_hit[g] = i_mem.valid && dw_ctrl_r[g][`DBG_CTRL_ENABLE] && thread_ok
                    && (!i_mem.load || dw_ctrl_r[g][`DBG_CTRL_LOAD])
                    && (dw_ctrl_r[g][`DBG_CTRL_COND] ? (above || below) : (above && below));
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Debug entry: the highest-priority cause is taken, lowest code first.
    logic enter;
    logic [2:0] cause_nxt;
    logic [1:0] index_nxt;
    logic [7:0] thread_nxt;
    logic info_load;
    logic [31:0] info_nxt;

    always_comb begin
        enter = !i_debug_mode;
        cause_nxt = `DBG_CAUSE_RESET;
        index_nxt = 2'h0;
        thread_nxt = 8'h00;
        info_load = 1'b0;
        info_nxt = info_r;
        if (i_host_req) begin
            cause_nxt = `DBG_CAUSE_HOST;
        end else if (i_swcall_req) begin
            cause_nxt = `DBG_CAUSE_SWCALL;
            thread_nxt = i_swcall_thread;
        end else if (|ibrk_hit) begin
            cause_nxt = `DBG_CAUSE_IBRK;
            thread_nxt = i_pc_thread;
            index_nxt = lowest_index(ibrk_hit);
        end else if (|dw_hit) begin
            cause_nxt = `DBG_CAUSE_DWATCH;
            thread_nxt = i_mem.thread;
            index_nxt = lowest_index(dw_hit);
            info_load = 1'b1;
            info_nxt = i_mem.addr;
        end else if (|i_res_hit) begin
            cause_nxt = `DBG_CAUSE_RES;
            thread_nxt = i_res_thread;
            index_nxt = lowest_index(i_res_hit);
            info_load = 1'b1;
            info_nxt = i_res_id;
        end else begin
            enter = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes. The core port writes only in debug mode; the configuration port writes scratch words unless locked.
    logic wr;
    assign wr = i_reg.sel && i_reg.write && i_debug_mode;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            status_r <= 32'h0000_0000;
            spc_r <= 32'h0000_0000;
            ssp_r <= 32'h0000_0000;
        end else if (enter) begin
            status_r <= i_saved.status & 32'h0000_07DF;
            spc_r <= i_saved.pc;
            ssp_r <= i_saved.sp;
        end else if (wr) begin
            if (i_reg.addr == `DBG_OFF_SAVED_STATUS) begin
                status_r <= (status_r & ~`DBG_STATUS_WR_MASK)
                    | (i_reg.wdata & `DBG_STATUS_WR_MASK);
            end
            if (i_reg.addr == `DBG_OFF_SAVED_PC) begin
                spc_r <= i_reg.wdata;
            end
            if (i_reg.addr == `DBG_OFF_SAVED_STACK) begin
                ssp_r <= i_reg.wdata;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cause_r <= `DBG_CAUSE_RESET;
            cause_index_r <= 2'h0;
            cause_thread_r <= 8'h00;
            info_r <= 32'h0000_0000;
        end else if (enter) begin
            cause_r <= cause_nxt;
            cause_index_r <= index_nxt;
            cause_thread_r <= thread_nxt;
            if (info_load) begin
                info_r <= info_nxt;
            end
        end else if (wr) begin
            if (i_reg.addr == `DBG_OFF_CAUSE) begin
                cause_r <= i_reg.wdata[`DBG_CAUSE_LSB +: 3];
                cause_index_r <= i_reg.wdata[`DBG_INDEX_LSB +: 2];
                cause_thread_r <= i_reg.wdata[`DBG_THREAD_LSB +: 8];
            end
            if (i_reg.addr == `DBG_OFF_INFO) begin
                info_r <= i_reg.wdata;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            remote_thread_r <= 8'h00;
            remote_reg_r <= 5'h00;
            stop_mask_r <= 8'h00;
        end else if (wr) begin
            if (i_reg.addr == `DBG_OFF_REMOTE_THREAD) begin
                remote_thread_r <= i_reg.wdata[7:0];
            end
            if (i_reg.addr == `DBG_OFF_REMOTE_REG) begin
                remote_reg_r <= i_reg.wdata[4:0];
            end
            if (i_reg.addr == `DBG_OFF_STOP_MASK) begin
                stop_mask_r <= i_reg.wdata[7:0];
            end
        end
    end

    // The core port wins a same-cycle write to one scratch word; the loser is dropped.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int k = 0; k < NUM_SCRATCH; k++) begin
                scratch_r[k] <= 32'h0000_0000;
            end
        end else begin
            for (int k = 0; k < NUM_SCRATCH; k++) begin
                if (wr && i_reg.addr == `DBG_OFF_SCRATCH + 8'(k)) begin
                    scratch_r[k] <= i_reg.wdata;
                end else if (i_cfg.sel && i_cfg.write && !i_cfg_wr_lock
                        && i_cfg.addr == `DBG_OFF_SCRATCH + 8'(k)) begin
                    scratch_r[k] <= i_cfg.wdata;
                end
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int k = 0; k < NUM_UNITS; k++) begin
                ibrk_addr_r[k] <= 32'h0000_0000;
                ibrk_ctrl_r[k] <= 32'h0000_0000;
                dw_first_r[k] <= 32'h0000_0000;
                dw_second_r[k] <= 32'h0000_0000;
                dw_ctrl_r[k] <= 32'h0000_0000;
            end
        end else if (wr) begin
            for (int k = 0; k < NUM_UNITS; k++) begin
                if (i_reg.addr == `DBG_OFF_IBRK_ADDR + 8'(k)) begin
                    ibrk_addr_r[k] <= i_reg.wdata;
                end
                if (i_reg.addr == `DBG_OFF_IBRK_CTRL + 8'(k)) begin
                    ibrk_ctrl_r[k] <= i_reg.wdata & `DBG_CTRL_WR_MASK & 32'hFFFF_FFFB;
                end
                if (i_reg.addr == `DBG_OFF_DW_FIRST + 8'(k)) begin
                    dw_first_r[k] <= i_reg.wdata;
                end
                if (i_reg.addr == `DBG_OFF_DW_SECOND + 8'(k)) begin
                    dw_second_r[k] <= i_reg.wdata;
                end
                if (i_reg.addr == `DBG_OFF_DW_CTRL + 8'(k)) begin
                    dw_ctrl_r[k] <= i_reg.wdata & `DBG_CTRL_WR_MASK;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read decode. Unmapped numbers and reserved bits read as zero.
    logic [31:0] rd_nxt;
    logic [31:0] cfg_rd_nxt;

    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (i_reg.addr)
            `DBG_OFF_SAVED_STATUS: rd_nxt = status_r;
            `DBG_OFF_SAVED_PC: rd_nxt = spc_r;
            `DBG_OFF_SAVED_STACK: rd_nxt = ssp_r;
            `DBG_OFF_REMOTE_THREAD: rd_nxt = {24'h000000, remote_thread_r};
            `DBG_OFF_REMOTE_REG: rd_nxt = {27'h0000000, remote_reg_r};
            `DBG_OFF_CAUSE: rd_nxt = {14'h0000, cause_index_r, cause_thread_r,
                5'h00, cause_r};
            `DBG_OFF_INFO: rd_nxt = info_r;
            `DBG_OFF_STOP_MASK: rd_nxt = {24'h000000, stop_mask_r};
            default: begin
                if (i_reg.addr[7:3] == `DBG_OFF_SCRATCH >> 3) begin
                    rd_nxt = scratch_r[i_reg.addr[2:0]];
                end else if (in_block4(i_reg.addr, `DBG_OFF_IBRK_ADDR)) begin
                    rd_nxt = ibrk_addr_r[i_reg.addr[1:0]];
                end else if (in_block4(i_reg.addr, `DBG_OFF_IBRK_CTRL)) begin
                    rd_nxt = ibrk_ctrl_r[i_reg.addr[1:0]];
                end else if (in_block4(i_reg.addr, `DBG_OFF_DW_FIRST)) begin
                    rd_nxt = dw_first_r[i_reg.addr[1:0]];
                end else if (in_block4(i_reg.addr, `DBG_OFF_DW_SECOND)) begin
                    rd_nxt = dw_second_r[i_reg.addr[1:0]];
                end else if (in_block4(i_reg.addr, `DBG_OFF_DW_CTRL)) begin
                    rd_nxt = dw_ctrl_r[i_reg.addr[1:0]];
                end
            end
        endcase
        cfg_rd_nxt = 32'h0000_0000;
        if (i_cfg.addr[7:3] == `DBG_OFF_SCRATCH >> 3) begin
            cfg_rd_nxt = scratch_r[i_cfg.addr[2:0]];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registered outputs.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_rdata <= 32'h0000_0000;
            o_cfg_rdata <= 32'h0000_0000;
        end else begin
            if (i_reg.sel && !i_reg.write) begin
                o_reg_rdata <= rd_nxt;
            end
            if (i_cfg.sel && !i_cfg.write) begin
                o_cfg_rdata <= cfg_rd_nxt;
            end
        end
    end

    // The stop vector is masked off while in debug so debug code can still drive threads.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_debug_irq <= 1'b0;
            o_thread_stop <= 8'h00;
            o_remote_thread <= 8'h00;
            o_remote_reg <= 5'h00;
        end else begin
            o_debug_irq <= enter;
            o_thread_stop <= i_debug_mode ? 8'h00 : stop_mask_r;
            o_remote_thread <= remote_thread_r;
            o_remote_reg <= remote_reg_r;
        end
    end
endmodule : dbg_regs

// *** verilog/dbg_consts.svh ***
// Purpose: Offsets, field positions, reset values and codes of the debug register block.
// Assumes: Register numbers are the processor-status register numbers.
// Notes: Definitions only.
`ifndef DBG_CONSTS_SVH
`define DBG_CONSTS_SVH
`define DBG_OFF_SAVED_STATUS 8'h10
`define DBG_OFF_SAVED_PC 8'h11
`define DBG_OFF_SAVED_STACK 8'h12
`define DBG_OFF_REMOTE_THREAD 8'h13
`define DBG_OFF_REMOTE_REG 8'h14
`define DBG_OFF_CAUSE 8'h15
`define DBG_OFF_INFO 8'h16
`define DBG_OFF_STOP_MASK 8'h18
`define DBG_OFF_SCRATCH 8'h20
`define DBG_OFF_IBRK_ADDR 8'h30
`define DBG_OFF_IBRK_CTRL 8'h40
`define DBG_OFF_DW_FIRST 8'h50
`define DBG_OFF_DW_SECOND 8'h60
`define DBG_OFF_DW_CTRL 8'h70
`define DBG_STATUS_WR_MASK 32'h0000_06DF
`define DBG_CTRL_WR_MASK 32'h00FF_0007
`define DBG_CTRL_ENABLE 0
`define DBG_CTRL_COND 1
`define DBG_CTRL_LOAD 2
`define DBG_CTRL_THREAD_LSB 16
`define DBG_CAUSE_LSB 0
`define DBG_INDEX_LSB 16
`define DBG_THREAD_LSB 8
`define DBG_CAUSE_RESET 3'h0
`define DBG_CAUSE_HOST 3'h1
`define DBG_CAUSE_SWCALL 3'h2
`define DBG_CAUSE_IBRK 3'h3
`define DBG_CAUSE_DWATCH 3'h4
`define DBG_CAUSE_RES 3'h5
`endif

// *** verilog/dbg_pkg.sv ***
// Purpose: Types shared by the debug register block.
// Assumes: Eight hardware threads.
// Notes: Constants live in dbg_consts.svh.
package dbg_pkg;
    typedef struct packed {
        logic sel;
        logic write;
        logic [7:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [31:0] status;
        logic [31:0] pc;
        logic [31:0] sp;
    } saved_state_t;

    typedef struct packed {
        logic valid;
        logic load;
        logic [7:0] thread;
        logic [31:0] addr;
    } mem_access_t;
endpackage : dbg_pkg

// *** verilog/ibrk_match.sv ***
// Purpose: Match test of one instruction breakpoint.
// Assumes: Control word holds enable, condition and per-thread mask.
// Notes: Purely combinational.
`timescale 1ns/10ps
`include "dbg_consts.svh"
module ibrk_match #(
    parameter int NUM_THREADS = 8
) (
    // Breakpoint setup
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_ctrl,
    // Executing instruction
    input wire logic i_valid,
    input wire logic [31:0] i_pc,
    input wire logic [7:0] i_thread,
    // Result
    output logic o_hit
);
    logic thread_ok;
    logic equal;

    always_comb begin
        thread_ok = 1'b0;
        if (i_thread < 8'(NUM_THREADS)) begin
            thread_ok = i_ctrl[`DBG_CTRL_THREAD_LSB + int'(i_thread)];
        end
        equal = (i_pc == i_addr);
        o_hit = i_valid && i_ctrl[`DBG_CTRL_ENABLE] && thread_ok
            && (i_ctrl[`DBG_CTRL_COND] ? !equal : equal);
    end
endmodule : ibrk_match

// *** tb/dbg_regs_chk.sv ***
// Purpose: Concurrent checks on the block's ports.
// Assumes: One clock; reset active low.
// Notes: Bound from the bench top file.
`timescale 1ns/10ps
module dbg_regs_chk (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Register ports
    input wire dbg_pkg::reg_req_t i_reg,
    input wire logic [31:0] o_reg_rdata,
    input wire dbg_pkg::reg_req_t i_cfg,
    input wire logic [31:0] o_cfg_rdata,
    // Core side
    input wire logic i_debug_mode,
    input wire logic i_pc_valid,
    input wire dbg_pkg::mem_access_t i_mem,
    input wire logic i_host_req,
    input wire logic i_swcall_req,
    input wire logic [3:0] i_res_hit,
    input wire logic o_debug_irq,
    input wire logic [7:0] o_thread_stop,
    input wire logic [7:0] o_remote_thread,
    input wire logic [4:0] o_remote_reg
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);
    logic any_cause;
    logic rd_core;
    logic wr_core;
    assign any_cause = i_host_req | i_swcall_req | i_pc_valid | i_mem.valid | (|i_res_hit);
    assign rd_core = i_reg.sel & ~i_reg.write;
    assign wr_core = i_reg.sel & i_reg.write & i_debug_mode;
    ////////////////////////////////////////////////////////////
    property p_host_entry;
        i_host_req && !i_debug_mode |=> o_debug_irq;
    endproperty
    a_host_entry: assert property (p_host_entry)
        else $error("host request gave no debug interrupt");
    property p_entry_outside;
        o_debug_irq |-> !$past(i_debug_mode) && $past(any_cause);
    endproperty
    a_entry_outside: assert property (p_entry_outside)
        else $error("entry without cause or in debug mode");
    property p_stop_quiet;
        i_debug_mode ##1 i_debug_mode |=> o_thread_stop == 8'h00;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet)
        else $error("threads stopped while in debug mode");
    property p_thread_op;
        wr_core && i_reg.addr == 8'h13 |-> ##2 o_remote_thread == $past(i_reg.wdata[7:0], 2);
    endproperty
    a_thread_op: assert property (p_thread_op)
        else $error("thread operand lost");
    property p_reg_op;
        wr_core && i_reg.addr == 8'h14 |-> ##2 o_remote_reg == $past(i_reg.wdata[4:0], 2);
    endproperty
    a_reg_op: assert property (p_reg_op)
        else $error("register operand lost");
    property p_status_rsvd;
        rd_core && i_reg.addr == 8'h10 |=> o_reg_rdata[31:11] == 21'h0 && !o_reg_rdata[5];
    endproperty
    a_status_rsvd: assert property (p_status_rsvd)
        else $error("reserved status bits read nonzero");
    property p_cause_rsvd;
        rd_core && i_reg.addr == 8'h15 |=> o_reg_rdata[31:18] == 14'h0 && o_reg_rdata[7:3] == 5'h0;
    endproperty
    a_cause_rsvd: assert property (p_cause_rsvd)
        else $error("reserved cause bits read nonzero");
    property p_cfg_unmapped;
        i_cfg.sel && !i_cfg.write && i_cfg.addr[7:3] != 5'h04 |=> o_cfg_rdata == 32'h0;
    endproperty
    a_cfg_unmapped: assert property (p_cfg_unmapped)
        else $error("unmapped configuration read nonzero");
    c_entry: cover property (o_debug_irq);
    c_cfg_write: cover property (i_cfg.sel && i_cfg.write);
    c_stopped: cover property (o_thread_stop != 8'h00);
endmodule : dbg_regs_chk

// *** tb/dbg_host.sv ***
// Purpose: Debugger model on both register ports.
// Assumes: One access per call, held for one edge.
// Notes: Read data is taken just after the taking edge.
`timescale 1ns/10ps
module dbg_host (
    // Clock
    input wire logic i_clock,
    // Register ports of the block
    output dbg_pkg::reg_req_t o_reg,
    output dbg_pkg::reg_req_t o_cfg,
    input wire logic [31:0] i_reg_rdata,
    input wire logic [31:0] i_cfg_rdata
);
    initial begin
        o_reg = '0;
        o_cfg = '0;
    end
    task automatic xfer(input logic c, input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] v);
        @(posedge i_clock);
        o_reg <= '{!c, w, a, d};
        o_cfg <= '{c, w, a, d};
        @(posedge i_clock);
        // Released lines show the inverse, so a stale address is never trusted.
        o_reg <= '{1'b0, 1'b0, ~a, ~d};
        o_cfg <= '{1'b0, 1'b0, ~a, ~d};
        #1;
        v = c ? i_cfg_rdata : i_reg_rdata;
    endtask : xfer
endmodule : dbg_host

// *** tb/dbg_regs_bench.sv ***
// Purpose: Self-checking bench of the debug register block.
// Assumes: The host model drives both register ports.
// Notes: An entry posts its cause for one edge.
`timescale 1ns/10ps
module dbg_regs_bench;
    localparam logic CORE = 1'b0;
    localparam logic CFG = 1'b1;
    logic i_clock = 1'b0;
    logic i_rst_b = 1'b0;
    logic dm = 1'b1;
    logic lock = 1'b0;
    dbg_pkg::saved_state_t sv = '0;
    logic pcv = 1'b0;
    logic [31:0] pc = 32'h0;
    logic [7:0] pct = 8'h00;
    dbg_pkg::mem_access_t mem = '0;
    logic host = 1'b0;
    logic swc = 1'b0;
    logic [7:0] swt = 8'h00;
    logic [3:0] rh = 4'h0;
    logic [7:0] rt = 8'h00;
    logic [31:0] rid = 32'h0;
    dbg_pkg::reg_req_t rq;
    dbg_pkg::reg_req_t cq;
    logic [31:0] rdat;
    logic [31:0] cdat;
    logic irq;
    logic [7:0] stop;
    logic [7:0] rthr;
    logic [4:0] rreg;
    int mismatches = 0;
    int checks_done = 0;
    dbg_regs u_dbg_regs (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_reg(rq), .o_reg_rdata(rdat),
        .i_cfg(cq), .i_cfg_wr_lock(lock), .o_cfg_rdata(cdat), .i_debug_mode(dm),
        .i_saved(sv), .i_pc_valid(pcv), .i_pc(pc), .i_pc_thread(pct), .i_mem(mem),
        .i_host_req(host), .i_swcall_req(swc), .i_swcall_thread(swt), .i_res_hit(rh),
        .i_res_thread(rt), .i_res_id(rid), .o_debug_irq(irq), .o_thread_stop(stop),
        .o_remote_thread(rthr), .o_remote_reg(rreg)
    );
    dbg_host u_dbg_host (
        .i_clock(i_clock), .o_reg(rq), .o_cfg(cq), .i_reg_rdata(rdat), .i_cfg_rdata(cdat)
    );
    initial begin
        forever #20 i_clock = ~i_clock;
    end
    ////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp
    task automatic wr(input logic c, input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        u_dbg_host.xfer(c, 1'b1, a, d, v);
    endtask : wr
    task automatic rd(input logic c, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        u_dbg_host.xfer(c, 1'b0, a, 32'h0, v);
        cmp(v, e);
    endtask : rd
    task automatic enter(input logic [2:0] k, input logic [7:0] t, input logic [31:0] v,
                         input logic e);
        @(posedge i_clock);
        dm <= 1'b0;
        sv <= '{v, ~v, v ^ 32'h0F0F_0F0F};
        case (k)
            3'h1: host <= 1'b1;
            3'h2: begin
                swc <= 1'b1;
                swt <= t;
            end
            3'h3: begin
                pcv <= 1'b1;
                pc <= v;
                pct <= t;
            end
            3'h4: mem <= '{1'b1, 1'b0, t, v};
            3'h6: mem <= '{1'b1, 1'b1, t, v};
            default: begin
                rh <= 4'h6;
                rt <= t;
                rid <= v;
            end
        endcase
        @(posedge i_clock);
        dm <= 1'b1;
        host <= 1'b0;
        swc <= 1'b0;
        pcv <= 1'b0;
        mem.valid <= 1'b0;
        rh <= 4'h0;
        #1;
        cmp({31'h0, irq}, {31'h0, e});
        @(posedge i_clock);
        #1;
        cmp({31'h0, irq}, 32'h0);
    endtask : enter
    // A hang counts as a mismatch.
    initial begin
        #1000000;
        mismatches++;
        complete_run();
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge i_clock);
        i_rst_b <= 1'b1;
        rd(CORE, 8'h15, 32'h0);
        rd(CORE, 8'h40, 32'h0);
        rd(CORE, 8'h43, 32'h0);
        wr(CORE, 8'h10, 32'hFFFF_FFFF);
        rd(CORE, 8'h10, 32'h0000_06DF);
        wr(CORE, 8'h13, 32'hFFFF_FFA7);
        rd(CORE, 8'h13, 32'h0000_00A7);
        wr(CORE, 8'h14, 32'hFFFF_FFF3);
        rd(CORE, 8'h14, 32'h0000_0013);
        cmp({24'h0, rthr}, 32'h0000_00A7);
        cmp({27'h0, rreg}, 32'h0000_0013);
        for (int i = 0; i < 8; i++) begin
            wr(CORE, 8'h20 + 8'(i), 32'h5C00_0000 + 32'(i));
            rd(CFG, 8'h20 + 8'(i), 32'h5C00_0000 + 32'(i));
        end
        wr(CFG, 8'h27, 32'h0000_C0DE);
        rd(CORE, 8'h27, 32'h0000_C0DE);
        @(posedge i_clock);
        lock <= 1'b1;
        wr(CFG, 8'h27, 32'h0000_0BAD);
        @(posedge i_clock);
        lock <= 1'b0;
        rd(CFG, 8'h27, 32'h0000_C0DE);
        rd(CFG, 8'h28, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(CORE, 8'h50 + 8'(i), 32'h0000_0100 + 32'(i));
            wr(CORE, 8'h60 + 8'(i), 32'h0000_01FF);
            rd(CORE, 8'h50 + 8'(i), 32'h0000_0100 + 32'(i));
            rd(CORE, 8'h60 + 8'(i), 32'h0000_01FF);
        end
        wr(CORE, 8'h18, 32'hFFFF_FF5A);
        rd(CORE, 8'h18, 32'h0000_005A);
        cmp({24'h0, stop}, 32'h0);
        @(posedge i_clock);
        dm <= 1'b0;
        wr(CORE, 8'h13, 32'h0000_0011);
        cmp({24'h0, stop}, 32'h0000_005A);
        @(posedge i_clock);
        dm <= 1'b1;
        rd(CORE, 8'h13, 32'h0000_00A7);
        cmp({24'h0, stop}, 32'h0);
        enter(3'h1, 8'h07, 32'hCAFE_F5A5, 1'b1);
        rd(CORE, 8'h15, 32'h0000_0001);
        rd(CORE, 8'h10, 32'hCAFE_F5A5 & 32'h0000_07DF);
        rd(CORE, 8'h11, ~32'hCAFE_F5A5);
        rd(CORE, 8'h12, 32'hCAFE_F5A5 ^ 32'h0F0F_0F0F);
        wr(CORE, 8'h11, 32'h0000_4000);
        rd(CORE, 8'h11, 32'h0000_4000);
        enter(3'h2, 8'h05, 32'h0, 1'b1);
        rd(CORE, 8'h15, 32'h0000_0502);
        wr(CORE, 8'h30, 32'h0000_0800);
        wr(CORE, 8'h31, 32'h0000_0400);
        wr(CORE, 8'h33, 32'h0000_0400);
        wr(CORE, 8'h41, 32'h0002_0001);
        wr(CORE, 8'h43, 32'h0002_0001);
        rd(CORE, 8'h43, 32'h0002_0001);
        enter(3'h3, 8'h01, 32'h0000_0400, 1'b1);
        rd(CORE, 8'h15, 32'h0001_0103);
        enter(3'h3, 8'h02, 32'h0000_0400, 1'b0);
        wr(CORE, 8'h41, 32'h0002_0000);
        enter(3'h3, 8'h01, 32'h0000_0400, 1'b1);
        rd(CORE, 8'h15, 32'h0003_0103);
        wr(CORE, 8'h40, 32'h0002_0003);
        enter(3'h3, 8'h01, 32'h0000_0400, 1'b1);
        rd(CORE, 8'h15, 32'h0000_0103);
        wr(CORE, 8'h40, 32'h0);
        wr(CORE, 8'h43, 32'h0);
        wr(CORE, 8'h70, 32'h0004_0001);
        enter(3'h4, 8'h02, 32'h0000_0180, 1'b1);
        rd(CORE, 8'h15, 32'h0000_0204);
        rd(CORE, 8'h16, 32'h0000_0180);
        enter(3'h6, 8'h02, 32'h0000_0180, 1'b0);
        wr(CORE, 8'h70, 32'h0004_0005);
        enter(3'h6, 8'h02, 32'h0000_01C0, 1'b1);
        wr(CORE, 8'h70, 32'h0);
        enter(3'h5, 8'h03, 32'hBEEF_0042, 1'b1);
        rd(CORE, 8'h15, 32'h0001_0305);
        rd(CORE, 8'h16, 32'hBEEF_0042);
        complete_run();
    end
endmodule : dbg_regs_bench
bind dbg_regs dbg_regs_chk u_dbg_regs_chk (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_reg(i_reg), .o_reg_rdata(o_reg_rdata),
    .i_cfg(i_cfg), .o_cfg_rdata(o_cfg_rdata), .i_debug_mode(i_debug_mode),
    .i_pc_valid(i_pc_valid), .i_mem(i_mem), .i_host_req(i_host_req),
    .i_swcall_req(i_swcall_req), .i_res_hit(i_res_hit), .o_debug_irq(o_debug_irq),
    .o_thread_stop(o_thread_stop), .o_remote_thread(o_remote_thread),
    .o_remote_reg(o_remote_reg)
);
